//--- verilog/acc_regs.vh
// Function
// - Offset trim is 24 bits: high register bits 23:8, low register 15:8 bits 7:0.
// - Gain trim is 24 bits: high register bits 23:8, low register 15:8 bits 7:0.
// - Gain high registers reset to 8000h; offset and gain low registers reset to zero.
// - Low trim registers bits 7:0 are read-only and always read zero.
// - Channel 1 config bits 15:6 hold signed 10-bit sample delay, reset zero.
// - Channel 1 config bit 2 turns DC removal off for channel 1 only.
// - Channel 1 config bits 1:0 select pins, shorted, positive or negative test.
// - Channel 1 config bits 5:3 are read-only and read zero.
// - Channel 1 registers decode at Eh, Fh, 10h, 11h and 12h.
// - Channel 0 gain trim high decodes at Ch, low at Dh.
// - Channel 0 offset trim low decodes at Bh and resets to zero.
// - Global 4-bit coefficient 0000b disables DC removal; 0001b..1111b select 1/4..1/65536.
`ifndef ACC_REGS_VH
`define ACC_REGS_VH
`define ACC_ADDR_CH0_OFS_LO 6'h0B
`define ACC_ADDR_CH0_GAIN_HI 6'h0C
`define ACC_ADDR_CH0_GAIN_LO 6'h0D
`define ACC_ADDR_CH1_CONFIG 6'h0E
`define ACC_ADDR_CH1_OFS_HI 6'h0F
`define ACC_ADDR_CH1_OFS_LO 6'h10
`define ACC_ADDR_CH1_GAIN_HI 6'h11
`define ACC_ADDR_CH1_GAIN_LO 6'h12
`define ACC_RST_GAIN_HI 16'h8000
`define ACC_RST_ZERO 16'h0000
`define ACC_CFG_DELAY_MSB 15
`define ACC_CFG_DELAY_LSB 6
`define ACC_CFG_DCOFF_BIT 2
`define ACC_CFG_MUX_MSB 1
`define ACC_CFG_MUX_LSB 0
`define ACC_LO_FIELD_MSB 15
`define ACC_LO_FIELD_LSB 8
`define ACC_DCCOEF_OFF 4'h0
`endif

//--- verilog/acc_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.vh"
module acc_bank
(
    input wire clk,
    input wire rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [5:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire [3:0] dc_removal_coefficient,
    input wire result_strobe,
    output reg [15:0] reg_rdata,
    output reg reg_hit,
    output reg [23:0] ch0_offset_low_applied,
    output reg [23:0] ch0_gain_applied,
    output reg [23:0] ch1_offset_applied,
    output reg [23:0] ch1_gain_applied,
    output reg [9:0] ch1_sample_delay,
    output reg ch1_dc_removal_off,
    output reg [1:0] ch1_input_select,
    output reg ch1_dc_removal_active
);
    // Applied copies only move on result_strobe so a result never sees a half update
    reg [7:0] ch0_offset_trim_low_reg;
    reg [15:0] ch0_gain_trim_high_reg;
    reg [7:0] ch0_gain_trim_low_reg;
    reg [9:0] delay_reg;
    reg dcoff_reg;
    reg [1:0] mux_reg;
    reg [15:0] ch1_offset_trim_high_reg;
    reg [7:0] ch1_offset_trim_low_reg;
    reg [15:0] ch1_gain_trim_high_reg;
    reg [7:0] ch1_gain_trim_low_reg;
    reg [15:0] rdata_next;
    reg hit_next;

    // Low registers carry only the upper byte
    function [15:0] lo_word;
        input [7:0] b;
        begin
            lo_word = {b, 8'h00};
        end
    endfunction

    always @*
    begin
        rdata_next = `ACC_RST_ZERO;
        hit_next = 1'b1;
        if (reg_addr == `ACC_ADDR_CH0_OFS_LO)
            rdata_next = lo_word(ch0_offset_trim_low_reg);
        else if (reg_addr == `ACC_ADDR_CH0_GAIN_HI)
            rdata_next = ch0_gain_trim_high_reg;
        else if (reg_addr == `ACC_ADDR_CH0_GAIN_LO)
            rdata_next = lo_word(ch0_gain_trim_low_reg);
        else if (reg_addr == `ACC_ADDR_CH1_CONFIG)
            rdata_next = {delay_reg, 3'b000, dcoff_reg, mux_reg};
        else if (reg_addr == `ACC_ADDR_CH1_OFS_HI)
            rdata_next = ch1_offset_trim_high_reg;
        else if (reg_addr == `ACC_ADDR_CH1_OFS_LO)
            rdata_next = lo_word(ch1_offset_trim_low_reg);
        else if (reg_addr == `ACC_ADDR_CH1_GAIN_HI)
            rdata_next = ch1_gain_trim_high_reg;
        else if (reg_addr == `ACC_ADDR_CH1_GAIN_LO)
            rdata_next = lo_word(ch1_gain_trim_low_reg);
        else
            hit_next = 1'b0;
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            ch0_offset_trim_low_reg <= 8'h00;
            ch0_gain_trim_high_reg <= `ACC_RST_GAIN_HI;
            ch0_gain_trim_low_reg <= 8'h00;
            delay_reg <= 10'h000;
            dcoff_reg <= 1'b0;
            mux_reg <= 2'b00;
            ch1_offset_trim_high_reg <= `ACC_RST_ZERO;
            ch1_offset_trim_low_reg <= 8'h00;
            ch1_gain_trim_high_reg <= `ACC_RST_GAIN_HI;
            ch1_gain_trim_low_reg <= 8'h00;
            reg_rdata <= `ACC_RST_ZERO;
            reg_hit <= 1'b0;
        end
        else
        begin
            if (reg_rd)
            begin
                reg_rdata <= rdata_next;
                reg_hit <= hit_next;
            end
            if (reg_wr)
            begin
                if (reg_addr == `ACC_ADDR_CH0_OFS_LO)
                    ch0_offset_trim_low_reg <= reg_wdata[`ACC_LO_FIELD_MSB:`ACC_LO_FIELD_LSB];
                else if (reg_addr == `ACC_ADDR_CH0_GAIN_HI)
                    ch0_gain_trim_high_reg <= reg_wdata;
                else if (reg_addr == `ACC_ADDR_CH0_GAIN_LO)
                    ch0_gain_trim_low_reg <= reg_wdata[`ACC_LO_FIELD_MSB:`ACC_LO_FIELD_LSB];
                else if (reg_addr == `ACC_ADDR_CH1_CONFIG)
                begin
                    delay_reg <= reg_wdata[`ACC_CFG_DELAY_MSB:`ACC_CFG_DELAY_LSB];
                    dcoff_reg <= reg_wdata[`ACC_CFG_DCOFF_BIT];
                    mux_reg <= reg_wdata[`ACC_CFG_MUX_MSB:`ACC_CFG_MUX_LSB];
                end
                else if (reg_addr == `ACC_ADDR_CH1_OFS_HI)
                    ch1_offset_trim_high_reg <= reg_wdata;
                else if (reg_addr == `ACC_ADDR_CH1_OFS_LO)
                    ch1_offset_trim_low_reg <= reg_wdata[`ACC_LO_FIELD_MSB:`ACC_LO_FIELD_LSB];
                else if (reg_addr == `ACC_ADDR_CH1_GAIN_HI)
                    ch1_gain_trim_high_reg <= reg_wdata;
                else if (reg_addr == `ACC_ADDR_CH1_GAIN_LO)
                    ch1_gain_trim_low_reg <= reg_wdata[`ACC_LO_FIELD_MSB:`ACC_LO_FIELD_LSB];
            end
        end
    end

    // Snapshot at result boundary; a write in the same cycle lands next result
    always @(posedge clk)
    begin
        if (rst)
        begin
            ch0_offset_low_applied <= 24'h00_0000;
            ch0_gain_applied <= 24'h80_0000;
            ch1_offset_applied <= 24'h00_0000;
            ch1_gain_applied <= 24'h80_0000;
            ch1_sample_delay <= 10'h000;
            ch1_dc_removal_off <= 1'b0;
            ch1_input_select <= 2'b00;
            ch1_dc_removal_active <= 1'b0;
        end
        else if (result_strobe)
        begin
            ch0_offset_low_applied <= {16'h0000, ch0_offset_trim_low_reg};
            ch0_gain_applied <= {ch0_gain_trim_high_reg, ch0_gain_trim_low_reg};
            ch1_offset_applied <= {ch1_offset_trim_high_reg, ch1_offset_trim_low_reg};
            ch1_gain_applied <= {ch1_gain_trim_high_reg, ch1_gain_trim_low_reg};
            ch1_sample_delay <= delay_reg;
            ch1_dc_removal_off <= dcoff_reg;
            ch1_input_select <= mux_reg;
            ch1_dc_removal_active <= ~dcoff_reg && (dc_removal_coefficient != `ACC_DCCOEF_OFF);
        end
    end
endmodule
`default_nettype wire

//--- test/acr_src.sv
`timescale 1ns/1ps
`default_nettype none
module acr_src #(parameter int LAG = 2)
(input wire logic clk, go, output logic stb);
// Result boundary arrives LAG+1 cycles after the request, as a slow pipeline would
logic [7:0] sh = 8'h00;
always @(posedge clk) sh <= {sh[6:0], go};
assign stb = sh[LAG];
endmodule
`default_nettype wire

//--- test/acr_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module acr_chk
(input wire clk, rst, reg_wr, reg_rd, result_strobe, reg_hit, ch1_dc_removal_off,
    input wire ch1_dc_removal_active, input wire [5:0] reg_addr,
    input wire [3:0] dc_removal_coefficient, input wire [15:0] reg_wdata, reg_rdata,
    input wire [23:0] ch1_gain_applied);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire map = reg_addr >= 6'h0B && reg_addr <= 6'h12;
wire cfg = reg_addr == 6'h0E;
property p_lo; reg_rd && reg_addr inside {6'h0B, 6'h0D, 6'h10, 6'h12} |=> ~|reg_rdata[7:0];
endproperty
property p_cfg; reg_rd && cfg |=> reg_rdata[5:3] == 3'h0; endproperty
property p_un; reg_rd && !map |=> !reg_hit && ~|reg_rdata; endproperty
property p_hit; reg_rd && map |=> reg_hit; endproperty
property p_wr; (reg_wr && cfg) ##1 !reg_wr ##1 (reg_rd && cfg)
    |=> reg_rdata == ($past(reg_wdata, 3) & 16'hFFC7); endproperty
property p_dc; result_strobe |=> ch1_dc_removal_active ==
    (!ch1_dc_removal_off && $past(dc_removal_coefficient) != 4'h0); endproperty
property p_hold; !result_strobe |=> $stable(ch1_gain_applied); endproperty
property p_rst; disable iff (1'h0) rst |=> ch1_gain_applied == 24'h80_0000 && !reg_hit;
endproperty
a_lo: assert property (p_lo) else $error("low byte set");
a_cfg: assert property (p_cfg) else $error("cfg reserved set");
a_un: assert property (p_un) else $error("unmapped hit");
a_hit: assert property (p_hit) else $error("mapped miss");
a_wr: assert property (p_wr) else $error("cfg readback");
a_dc: assert property (p_dc) else $error("dc active");
a_hold: assert property (p_hold) else $error("applied moved");
a_rst: assert property (p_rst) else $error("reset value");
c_dc: cover property (result_strobe ##1 ch1_dc_removal_active);
c_un: cover property (reg_rd && !map);
c_wr: cover property (reg_wr && cfg);
endmodule
`default_nettype wire

//--- test/tb_adc_channel_calibration_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_channel_calibration_regs;
logic clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, go = 1'h0, result_strobe, reg_hit;
logic ch1_dc_removal_off, ch1_dc_removal_active;
logic [5:0] reg_addr = 6'h00;
logic [15:0] reg_wdata = 16'h0000, reg_rdata;
logic [3:0] dc_removal_coefficient = 4'h0;
logic [23:0] ch0_offset_low_applied, ch0_gain_applied, ch1_offset_applied, ch1_gain_applied;
logic [9:0] ch1_sample_delay;
logic [1:0] ch1_input_select;
int err_count = 0, n_checks = 0;
always #2 clk = ~clk;
acr_src #(.LAG(2)) src (.clk, .go, .stb(result_strobe));
acc_bank dut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .dc_removal_coefficient,
    .result_strobe, .reg_rdata, .reg_hit, .ch0_offset_low_applied, .ch0_gain_applied,
    .ch1_offset_applied, .ch1_gain_applied, .ch1_sample_delay, .ch1_dc_removal_off,
    .ch1_input_select, .ch1_dc_removal_active);
task chk(input logic [23:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
        err_count++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
endtask
task rd(input logic [5:0] a, input logic [16:0] e);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk({7'h00, reg_hit, reg_rdata}, {7'h00, e});
endtask
task str;
    @(posedge clk);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
endtask
task close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
initial
begin
    #20000;
    err_count++;
    close_out;
end
initial
begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 8; i++)
        rd(6'h0B + 6'(i), {1'h1, (i == 1 || i == 6) ? 16'h8000 : 16'h0000});
    $display("reset test done");
    for (int i = 0; i < 8; i++)
        wr(6'h0B + 6'(i), {8'hA0 + 8'(i), 8'h50 + 8'(i)});
    chk(ch1_gain_applied, 24'h80_0000);
    for (int i = 0; i < 8; i++)
        rd(6'h0B + 6'(i), {1'h1, {8'hA0 + 8'(i), 8'h50 + 8'(i)} & ((i == 1 || i == 4 ||
            i == 6) ? 16'hFFFF : (i == 3) ? 16'hFFC7 : 16'hFF00)});
    str;
    chk(ch1_gain_applied, 24'hA6_56A7);
    chk(ch1_offset_applied, 24'hA4_54A5);
    chk(ch0_gain_applied, 24'hA1_51A2);
    chk(ch0_offset_low_applied, 24'h00_00A0);
    rd(6'h0A, 17'h0_0000);
    rd(6'h13, 17'h0_0000);
    $display("map test done");
    for (int m = 0; m < 4; m++)
    begin
        @(posedge clk) dc_removal_coefficient <= 4'(m);
        wr(6'h0E, {10'h155 ^ 10'(m), 3'h7, 1'(m), 2'(m)});
        rd(6'h0E, {1'h1, 10'h155 ^ 10'(m), 3'h0, 1'(m), 2'(m)});
        str;
        chk({ch1_sample_delay, ch1_dc_removal_off, ch1_input_select, ch1_dc_removal_active},
            {10'h155 ^ 10'(m), 1'(m), 2'(m), m == 2});
    end
    $display("config test done");
    @(posedge clk) rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd(6'h11, {1'h1, 16'h8000});
    rd(6'h0E, {1'h1, 16'h0000});
    chk(ch1_gain_applied, 24'h80_0000);
    $display("second reset test done");
    close_out;
end
endmodule
bind acc_bank acr_chk u_chk (.clk, .rst, .reg_wr, .reg_rd, .result_strobe, .reg_hit,
    .ch1_dc_removal_off, .ch1_dc_removal_active, .reg_addr, .dc_removal_coefficient,
    .reg_wdata, .reg_rdata, .ch1_gain_applied);
`default_nettype wire
